/* inc/pcis_defs.svh */
// Offsets, field positions, reset values and size limits of the config subset
`ifndef PCIS_DEFS_SVH
`define PCIS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PCIS_OFS_CMD        8'h04
`define PCIS_OFS_DEVCTL     8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCIS_CMD_INTDIS_BIT 10
`define PCIS_DC_MPS_LSB     5
`define PCIS_DC_MPS_MSB     7
`define PCIS_DC_MRRS_LSB    12
`define PCIS_DC_MRRS_MSB    14
`define PCIS_BE_LOW         0
`define PCIS_BE_HIGH        1

// ----------------------------------------
// Reset values and size encodings
// ----------------------------------------
`define PCIS_INTDIS_RST     1'h0
`define PCIS_MPS_RST        3'h0
`define PCIS_MRRS_RST       3'h2
`define PCIS_SIZE_CODE_MAX  3'h5
`define PCIS_SIZE_MIN_BYTES 13'h0080
`define PCIS_SIZE_MAX_BYTES 13'h1000

`endif

/* inc/pcis_pkg.sv */
// Types shared by the config subset and its INTx gate
package pcis_pkg;

	// ----------------------------------------
	// Config access port
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  func;
		logic [7:0]  offset;
		logic [1:0]  byte_en;
		logic [15:0] wdata;
	} pcis_cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
	} pcis_cfg_rsp_t;

	// ----------------------------------------
	// INTx virtual-wire message
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		logic       is_assert;
		logic [2:0] func;
		logic [1:0] pin;
	} pcis_intx_msg_t;

	// ----------------------------------------
	// Transfer size request and grant
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic        is_read;
		logic [2:0]  func;
		logic [12:0] len;
	} pcis_xfer_t;

endpackage : pcis_pkg

/* hw/pcis_intx_gate.sv */
// One function's INTx virtual-wire state and pending message selection
`timescale 1ns/1ps
module pcis_intx_gate (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic       int_dis,
	input  wire logic [3:0] intx_req,
	input  wire logic       grant,
	// Pending message
	output logic            pend,
	output logic            pend_assert,
	output logic [1:0]      pend_pin,
	output logic [3:0]      wire_state
);
	import pcis_pkg::*;

	logic [3:0] wire_r;
	logic [3:0] desired;
	logic [3:0] diff;

	// Masked wires want to be low, so a set mask turns every raised wire into a deassert
	assign desired = intx_req & {4{~int_dis}};
	assign diff    = desired ^ wire_r;

	always_comb
	begin
		pend        = 1'b0;
		pend_pin    = 2'h0;
		pend_assert = 1'b0;
		for (int i = 3; i >= 0; i--)
		begin
			if (diff[i])
			begin
				pend        = 1'b1;
				pend_pin    = 2'(i);
				pend_assert = desired[i];
			end
		end
	end

	// ----------------------------------------
	// Wire state as last signalled on the link
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
			wire_r <= 4'h0;
		else if (grant)
			wire_r[pend_pin] <= pend_assert;
	end

	assign wire_state = wire_r;

endmodule : pcis_intx_gate

/* hw/pcis_cfg_top.sv */
// Command and device-control config subset with INTx gating and size limits
`timescale 1ns/1ps
`include "pcis_defs.svh"

module pcis_cfg_top #(
	parameter int NUM_FUNC  = 1,
	parameter bit INTX_CAP  = 1'b1,
	parameter bit MPS_RW    = 1'b1,
	parameter bit MRRS_RW   = 1'b1
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Config access
	input  wire pcis_pkg::pcis_cfg_req_t cfg_req,
	output pcis_pkg::pcis_cfg_rsp_t      cfg_rsp,
	// Own INTx requests, four per function
	input  wire logic [4*NUM_FUNC-1:0]   intx_req,
	// INTx message channel
	output pcis_pkg::pcis_intx_msg_t     intx_msg,
	input  wire logic                    intx_msg_ready,
	// Forwarded INTx from below
	input  wire logic [3:0]              fwd_intx_in,
	output logic [3:0]                   fwd_intx_out,
	// Transfer size clamp
	input  wire pcis_pkg::pcis_xfer_t    xfer_req,
	output pcis_pkg::pcis_xfer_t         xfer_grant,
	// Limits in bytes per function
	output logic [13*NUM_FUNC-1:0]       payload_bytes,
	output logic [13*NUM_FUNC-1:0]       read_bytes
);
	import pcis_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                  int_dis_r  [NUM_FUNC];
	logic [2:0]            mps_r      [NUM_FUNC];
	logic [2:0]            mrrs_r     [NUM_FUNC];
	pcis_cfg_rsp_t         cfg_rsp_r;
	pcis_intx_msg_t        intx_msg_r;
	pcis_xfer_t            xfer_grant_r;
	logic [3:0]            fwd_intx_r;
	logic [13*NUM_FUNC-1:0] payload_bytes_r;
	logic [13*NUM_FUNC-1:0] read_bytes_r;
	logic [NUM_FUNC-1:0]   pend;
	logic [NUM_FUNC-1:0]   pend_assert;
	logic [1:0]            pend_pin   [NUM_FUNC];
	logic [NUM_FUNC-1:0]   grant;
	logic                  slot_free;
	logic                  func_ok;
	logic                  xfer_ok;
	logic [15:0]           rdata_nxt;
	logic [12:0]           lim_nxt;

	// Reserved encodings above the largest size are treated as the largest size
	function automatic logic [12:0] size_bytes(input logic [2:0] code);
		if (code > `PCIS_SIZE_CODE_MAX)
			return `PCIS_SIZE_MAX_BYTES;
		return 13'(`PCIS_SIZE_MIN_BYTES << code);
	endfunction : size_bytes

	assign func_ok = 32'(cfg_req.func) < NUM_FUNC;
	assign xfer_ok = 32'(xfer_req.func) < NUM_FUNC;

	// ----------------------------------------
	// Config writes, one register set per function
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		for (int f = 0; f < NUM_FUNC; f++)
		begin
			if (!nrst)
			begin
				int_dis_r[f] <= `PCIS_INTDIS_RST;
				mps_r[f]     <= `PCIS_MPS_RST;
				mrrs_r[f]    <= `PCIS_MRRS_RST;
			end
			else if (cfg_req.valid && cfg_req.write && func_ok && 32'(cfg_req.func) == f)
			begin
				// Only the addressed function changes state
				if (cfg_req.offset == `PCIS_OFS_CMD && cfg_req.byte_en[`PCIS_BE_HIGH]
					&& INTX_CAP)
					int_dis_r[f] <= cfg_req.wdata[`PCIS_CMD_INTDIS_BIT];
				if (cfg_req.offset == `PCIS_OFS_DEVCTL)
				begin
					if (cfg_req.byte_en[`PCIS_BE_LOW] && MPS_RW)
						mps_r[f] <= cfg_req.wdata[`PCIS_DC_MPS_MSB:`PCIS_DC_MPS_LSB];
					if (cfg_req.byte_en[`PCIS_BE_HIGH] && MRRS_RW)
						mrrs_r[f] <= cfg_req.wdata[`PCIS_DC_MRRS_MSB:`PCIS_DC_MRRS_LSB];
				end
			end
		end
	end

	// ----------------------------------------
	// Config reads
	// ----------------------------------------
	always_comb
	begin
		rdata_nxt = 16'h0000;
		for (int f = 0; f < NUM_FUNC; f++)
		begin
			if (func_ok && 32'(cfg_req.func) == f)
			begin
				if (cfg_req.offset == `PCIS_OFS_CMD)
					rdata_nxt[`PCIS_CMD_INTDIS_BIT] = INTX_CAP & int_dis_r[f];
				else if (cfg_req.offset == `PCIS_OFS_DEVCTL)
				begin
					// Hardwired variants read their constant 000b
					rdata_nxt[`PCIS_DC_MPS_MSB:`PCIS_DC_MPS_LSB] =
						MPS_RW ? mps_r[f] : `PCIS_MPS_RST;
					rdata_nxt[`PCIS_DC_MRRS_MSB:`PCIS_DC_MRRS_LSB] =
						MRRS_RW ? mrrs_r[f] : 3'h0;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			cfg_rsp_r <= '0;
		else
		begin
			cfg_rsp_r.ack   <= cfg_req.valid;
			cfg_rsp_r.rdata <= (cfg_req.valid && !cfg_req.write) ? rdata_nxt : 16'h0000;
		end
	end

	// ----------------------------------------
	// INTx gates, one per function
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_FUNC; g++)
		begin : gen_gate
			pcis_intx_gate u_gate (
				.clk         (clk),
				.nrst        (nrst),
				.int_dis     (INTX_CAP & int_dis_r[g]),
				.intx_req    (intx_req[4*g+3:4*g]),
				.grant       (grant[g]),
				.pend        (pend[g]),
				.pend_assert (pend_assert[g]),
				.pend_pin    (pend_pin[g]),
				.wire_state  ()
			);
		end
	endgenerate

	// ----------------------------------------
	// Message arbitration, lowest function first
	// ----------------------------------------
	assign slot_free = !intx_msg_r.valid || intx_msg_ready;

	always_comb
	begin
		grant = '0;
		for (int f = NUM_FUNC - 1; f >= 0; f--)
		begin
			if (pend[f] && slot_free)
			begin
				grant    = '0;
				grant[f] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			intx_msg_r <= '0;
		else if (slot_free)
		begin
			intx_msg_r.valid <= |grant;
			for (int f = 0; f < NUM_FUNC; f++)
			begin
				if (grant[f])
				begin
					intx_msg_r.is_assert <= pend_assert[f];
					intx_msg_r.func      <= 3'(f);
					intx_msg_r.pin       <= pend_pin[f];
				end
			end
		end
	end

	// ----------------------------------------
	// Forwarded INTx, never masked
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
			fwd_intx_r <= 4'h0;
		else
			fwd_intx_r <= fwd_intx_in;
	end

	// ----------------------------------------
	// Size limits and transfer clamp
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		for (int f = 0; f < NUM_FUNC; f++)
		begin
			if (!nrst)
			begin
				payload_bytes_r[13*f+:13] <= `PCIS_SIZE_MIN_BYTES;
				read_bytes_r[13*f+:13]    <= `PCIS_SIZE_MIN_BYTES;
			end
			else
			begin
				payload_bytes_r[13*f+:13] <= size_bytes(MPS_RW ? mps_r[f] : 3'h0);
				read_bytes_r[13*f+:13]    <= size_bytes(MRRS_RW ? mrrs_r[f] : 3'h0);
			end
		end
	end

	// Clamps against the live field, so a rewrite takes effect on the next request
	always_comb
	begin
		lim_nxt = `PCIS_SIZE_MIN_BYTES;
		for (int f = 0; f < NUM_FUNC; f++)
		begin
			if (xfer_ok && 32'(xfer_req.func) == f)
				lim_nxt = xfer_req.is_read ? size_bytes(MRRS_RW ? mrrs_r[f] : 3'h0)
					: size_bytes(MPS_RW ? mps_r[f] : 3'h0);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			xfer_grant_r <= '0;
		else
		begin
			xfer_grant_r.valid   <= xfer_req.valid && xfer_ok;
			xfer_grant_r.is_read <= xfer_req.is_read;
			xfer_grant_r.func    <= xfer_req.func;
			xfer_grant_r.len     <= (xfer_req.len > lim_nxt) ? lim_nxt : xfer_req.len;
		end
	end

	assign cfg_rsp       = cfg_rsp_r;
	assign intx_msg      = intx_msg_r;
	assign fwd_intx_out  = fwd_intx_r;
	assign xfer_grant    = xfer_grant_r;
	assign payload_bytes = payload_bytes_r;
	assign read_bytes    = read_bytes_r;

endmodule : pcis_cfg_top

/* tb/pcis_cfg_sva.sv */
// Port-level assertions for the config subset
`timescale 1ns/1ps
module pcis_cfg_sva
	import pcis_pkg::*;
#(
	parameter int NUM_FUNC = 1,
	parameter bit INTX_CAP = 1'b1
) (
	// Clock and reset
	input wire logic           clk,
	input wire logic           nrst,
	// Watched ports
	input wire pcis_cfg_req_t  cfg_req,
	input wire pcis_cfg_rsp_t  cfg_rsp,
	input wire pcis_intx_msg_t intx_msg,
	input wire logic           intx_msg_ready,
	input wire logic [3:0]     fwd_intx_in,
	input wire logic [3:0]     fwd_intx_out,
	input wire pcis_xfer_t     xfer_req,
	input wire pcis_xfer_t     xfer_grant
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Shadow of function 0 mask, so gating is judged without peeking inside
	logic dis0_r;
	always_ff @(posedge clk)
		if (!nrst)
			dis0_r <= 1'b0;
		else if (cfg_req.valid && cfg_req.write && cfg_req.func == 3'h0
			&& cfg_req.offset == 8'h04 && cfg_req.byte_en[1] && INTX_CAP)
			dis0_r <= cfg_req.wdata[10];

	property p_fwd; nrst |=> fwd_intx_out == $past(fwd_intx_in); endproperty
	a_fwd: assert property (p_fwd) else $error("forwarded intx changed");
	property p_mask;
		$rose(intx_msg.valid) && intx_msg.is_assert && intx_msg.func == 3'h0 |-> !$past(dis0_r);
	endproperty
	a_mask: assert property (p_mask) else $error("assert sent while masked");
	property p_hold; intx_msg.valid && !intx_msg_ready |=> $stable(intx_msg); endproperty
	a_hold: assert property (p_hold) else $error("message dropped");
	property p_shrink; xfer_req.valid |=> xfer_grant.len <= $past(xfer_req.len); endproperty
	a_shrink: assert property (p_shrink) else $error("grant grew");
	property p_cap; xfer_grant.valid |-> xfer_grant.len <= 13'h1000; endproperty
	a_cap: assert property (p_cap) else $error("grant above 4096");
	property p_badf; xfer_req.valid && xfer_req.func >= NUM_FUNC |=> !xfer_grant.valid; endproperty
	a_badf: assert property (p_badf) else $error("grant for absent function");
	property p_min;
		xfer_req.valid && xfer_req.func < NUM_FUNC && xfer_req.len <= 13'h0080
			|=> xfer_grant.valid && xfer_grant.len == $past(xfer_req.len);
	endproperty
	a_min: assert property (p_min) else $error("small transfer cut");
	property p_ack; nrst |=> cfg_rsp.ack == $past(cfg_req.valid); endproperty
	a_ack: assert property (p_ack) else $error("config ack wrong");
endmodule : pcis_cfg_sva

bind pcis_cfg_top pcis_cfg_sva #(.NUM_FUNC(NUM_FUNC), .INTX_CAP(INTX_CAP)) u_sva (
	.clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .intx_msg(intx_msg),
	.intx_msg_ready(intx_msg_ready), .fwd_intx_in(fwd_intx_in),
	.fwd_intx_out(fwd_intx_out), .xfer_req(xfer_req), .xfer_grant(xfer_grant));

/* tb/pcis_cfg_top_tb_top.sv */
// Self-checking bench for the config subset
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pcis_cfg_top_tb_top;
	import pcis_pkg::*;
	logic           clk, nrst, intx_msg_ready;
	pcis_cfg_req_t  cfg_req;
	pcis_cfg_rsp_t  cfg_rsp;
	pcis_intx_msg_t intx_msg;
	pcis_xfer_t     xfer_req, xfer_grant;
	logic [7:0]     intx_req;
	logic [3:0]     fwd_intx_in, fwd_intx_out;
	logic [25:0]    payload_bytes, read_bytes;
	pcis_cfg_rsp_t  cfg_rsp2;
	pcis_xfer_t     xfer_grant2;
	logic [25:0]    payload_bytes2, read_bytes2;
	int             compares = 0;
	int             mismatches = 0;

	pcis_cfg_top #(.NUM_FUNC(2)) uut (.clk(clk), .nrst(nrst), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .intx_req(intx_req), .intx_msg(intx_msg),
		.intx_msg_ready(intx_msg_ready), .fwd_intx_in(fwd_intx_in),
		.fwd_intx_out(fwd_intx_out), .xfer_req(xfer_req), .xfer_grant(xfer_grant),
		.payload_bytes(payload_bytes), .read_bytes(read_bytes));

	// Variant without the mask and with both size fields hardwired
	pcis_cfg_top #(.NUM_FUNC(2), .INTX_CAP(1'b0), .MPS_RW(1'b0), .MRRS_RW(1'b0)) uut_fixed (
		.clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp2), .intx_req(intx_req),
		.intx_msg(), .intx_msg_ready(intx_msg_ready), .fwd_intx_in(fwd_intx_in),
		.fwd_intx_out(), .xfer_req(xfer_req), .xfer_grant(xfer_grant2),
		.payload_bytes(payload_bytes2), .read_bytes(read_bytes2));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] o,
		input logic [1:0] be, input logic [15:0] d, input logic [15:0] e);
		@(negedge clk);
		cfg_req = '{1'b1, w, f, o, be, d};
		@(negedge clk);
		cfg_req = '0;
		`CHK("ack", 1'b1, cfg_rsp.ack)
		`CHK("rdata", e, cfg_rsp.rdata)
	endtask : cfg

	task automatic xfer(input logic rd, input logic [2:0] f, input logic [12:0] l,
		input logic v, input logic [12:0] e);
		@(negedge clk);
		xfer_req = '{1'b1, rd, f, l};
		@(negedge clk);
		xfer_req = '0;
		`CHK("grant valid", v, xfer_grant.valid)
		if (v)
			`CHK("grant len", e, xfer_grant.len)
	endtask : xfer

	// Waits for a message; the consumer is ready, so the next edge takes it
	task automatic msg(input logic a, input logic [2:0] f, input logic [1:0] p);
		int n;
		n = 0;
		while (intx_msg.valid !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		`CHK("intx msg", {1'b1, a, f, p}, intx_msg)
		if (n == 20)
			test_done();
		@(negedge clk);
	endtask : msg

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		cfg(1'b0, 3'h0, 8'h04, 2'h3, 16'h0000, 16'h0000);
		cfg(1'b0, 3'h0, 8'h08, 2'h3, 16'h0000, 16'h2000);
		`CHK("payload", 13'h0080, payload_bytes[12:0])
		`CHK("readlim", 13'h0200, read_bytes[12:0])
	endtask : t_reset_values

	task automatic t_fields;
		cfg(1'b1, 3'h0, 8'h08, 2'h3, 16'h5060, 16'h0000);
		cfg(1'b0, 3'h0, 8'h08, 2'h3, 16'h0000, 16'h5060);
		`CHK("payload", 13'h0400, payload_bytes[12:0])
		`CHK("readlim", 13'h1000, read_bytes[12:0])
		cfg(1'b1, 3'h1, 8'h08, 2'h1, 16'h70E0, 16'h0000);
		cfg(1'b0, 3'h1, 8'h08, 2'h3, 16'h0000, 16'h20E0);
		cfg(1'b0, 3'h0, 8'h0C, 2'h3, 16'h0000, 16'h0000);
		cfg(1'b1, 3'h3, 8'h08, 2'h3, 16'h1020, 16'h0000);
		cfg(1'b0, 3'h3, 8'h08, 2'h3, 16'h0000, 16'h0000);
		`CHK("payload f1", 13'h1000, payload_bytes[25:13])
		`CHK("readlim f1", 13'h0200, read_bytes[25:13])
	endtask : t_fields

	task automatic t_clamp;
		xfer(1'b0, 3'h0, 13'h07D0, 1'b1, 13'h0400);
		xfer(1'b1, 3'h0, 13'h1000, 1'b1, 13'h1000);
		xfer(1'b1, 3'h1, 13'h0300, 1'b1, 13'h0200);
		xfer(1'b0, 3'h1, 13'h012C, 1'b1, 13'h012C);
		xfer(1'b1, 3'h0, 13'h0040, 1'b1, 13'h0040);
		xfer(1'b0, 3'h2, 13'h0100, 1'b0, 13'h0000);
	endtask : t_clamp

	task automatic t_intx;
		intx_req = 8'h21;
		repeat (4) @(negedge clk);
		`CHK("held", 1'b1, intx_msg.valid)
		intx_msg_ready = 1'b1;
		msg(1'b1, 3'h0, 2'h0);
		msg(1'b1, 3'h1, 2'h1);
		cfg(1'b1, 3'h0, 8'h04, 2'h2, 16'h0400, 16'h0000);
		msg(1'b0, 3'h0, 2'h0);
		// Function 0 raises pin B while masked, function 1 drops pin B
		intx_req = 8'h03;
		msg(1'b0, 3'h1, 2'h1);
		fwd_intx_in = 4'hA;
		repeat (6) @(negedge clk);
		`CHK("quiet", 1'b0, intx_msg.valid)
		`CHK("forward", 4'hA, fwd_intx_out)
		cfg(1'b0, 3'h0, 8'h04, 2'h3, 16'h0000, 16'h0400);
		cfg(1'b1, 3'h0, 8'h04, 2'h2, 16'h0000, 16'h0000);
		msg(1'b1, 3'h0, 2'h0);
		msg(1'b1, 3'h0, 2'h1);
	endtask : t_intx

	task automatic t_fixed;
		cfg(1'b1, 3'h0, 8'h08, 2'h3, 16'h5060, 16'h0000);
		cfg(1'b0, 3'h0, 8'h08, 2'h3, 16'h0000, 16'h5060);
		`CHK("fixed devctl", 16'h0000, cfg_rsp2.rdata)
		cfg(1'b1, 3'h0, 8'h04, 2'h2, 16'h0400, 16'h0000);
		cfg(1'b0, 3'h0, 8'h04, 2'h3, 16'h0000, 16'h0400);
		`CHK("fixed cmd", 16'h0000, cfg_rsp2.rdata)
		`CHK("fixed payload", 13'h0080, payload_bytes2[12:0])
		`CHK("fixed readlim", 13'h0080, read_bytes2[12:0])
		xfer(1'b1, 3'h0, 13'h0300, 1'b1, 13'h0300);
		`CHK("fixed grant", 13'h0080, xfer_grant2.len)
	endtask : t_fixed

	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial
	begin
		nrst = 1'b0;
		cfg_req = '0;
		xfer_req = '0;
		intx_req = '0;
		intx_msg_ready = 1'b0;
		fwd_intx_in = '0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_reset_values();
		t_fields();
		t_clamp();
		t_intx();
		t_fixed();
		test_done();
	end
endmodule : pcis_cfg_top_tb_top
